// ---- ltc_host_model.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Host microcontroller pins, driven from bench requests
module ltc_host_model (
   // Requests from the bench
   input wire logic txReq,
   input wire logic enReq,
   // Device side of the transmit pin
   input wire logic txdOut,
   input wire logic txdOe,
   // Host pins seen by the device
   output logic txdIn,
   output logic modeEnable
);
   // Shared transmit pin: device drives in fail-safe, otherwise host level
   assign txdIn = txdOe ? txdOut : txReq;
   // Enable pin follows the host request
   assign modeEnable = enReq;
endmodule

// ---- ltc_pkg.sv ----
package ltc_pkg;
   // Clock rate in kHz
   localparam int CLK_KHZ = 10000;
   // Times as specified, in their own units
   localparam int REARM_US = 10;
   localparam int DOM_TIMEOUT_MS = 20;
   localparam int RESET_HOLD_MS = 4;
   localparam int WAKE_DOM_US = 100;
   localparam int RESET_FALL_US = 10;
   // Cycle counts; least times round up, longest times round down
   localparam int REARM_CYC = (REARM_US * CLK_KHZ + 999) / 1000 + 1;
   localparam int DOM_TIMEOUT_CYC = (DOM_TIMEOUT_MS * CLK_KHZ) + 1;
   localparam int RESET_HOLD_CYC = RESET_HOLD_MS * CLK_KHZ;
   localparam int WAKE_DOM_CYC = (WAKE_DOM_US * CLK_KHZ + 999) / 1000;
   localparam int RESET_FALL_CYC = (RESET_FALL_US * CLK_KHZ) / 1000;
   // Counter width shared by all timers
   localparam int TMR_W = 20;
   // Fail-safe source codes; the transmit pin is high for SRC_WAKE, low for the others
   localparam logic [1:0] SRC_POWERUP = 2'h0;
   localparam logic [1:0] SRC_UNDERVOLT = 2'h1;
   localparam logic [1:0] SRC_WAKE = 2'h2;
   // Operating modes
   typedef enum logic [1:0] {MODE_FAILSAFE, MODE_NORMAL, MODE_SILENT, MODE_SLEEP} ltc_mode_t;
endpackage

// ---- ltc_timer.sv ----
`timescale 1ns/10ps
// Qualified-time counter: counts while the condition holds, restarts when it drops
module ltc_timer #(
   parameter int LIMIT = 10
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // Condition and result
   input wire logic cond,
   output logic done
);
   // Current count
   logic [ltc_pkg::TMR_W-1:0] count;
   logic [ltc_pkg::TMR_W-1:0] next_count;
   logic next_done;
   localparam logic [ltc_pkg::TMR_W-1:0] LIM = ltc_pkg::TMR_W'(LIMIT);

   // Next count, saturating at the limit
   always_comb
   begin
      next_count = count;
      if (!cond)
      begin
         next_count = '0;
      end
      else if (count < LIM)
      begin
         next_count = count + 1'b1;
      end
      next_done = cond && (next_count >= LIM);
   end

   // Registers
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         count <= '0;
         done <= 1'b0;
      end
      else if (clkEn)
      begin
         count <= next_count;
         done <= next_done;
      end
   end
endmodule

// ---- ltc_transceiver_ctrl.sv ----
`timescale 1ns/10ps
// Function
// RULE1 - Transmit low drives bus dominant, else recessive
// RULE2 - Low transmit on normal entry blocks driver
// RULE3 - Transmit low beyond 20ms forces recessive
// RULE4 - Re-arm driver after 10us transmit high
// RULE5 - Receive output follows bus in normal
// RULE6 - Receive output held high in silent
// RULE7 - Fail-safe: transmit pin reports entry source
// RULE8 - Power-up enters fail-safe, regulator on
// RULE9 - Supply undervoltage disables bus transmission
// RULE10 - Regulator undervoltage asserts reset after delay
// RULE11 - Reset held 4ms after regulator recovers
// RULE12 - Overtemperature disables bus, regulator stays on
// RULE13 - Sleep accepted with stuck-low transmit
// RULE14 - Sleep decision uses raw transmit level
// RULE15 - Ended ground short counts as wake
// RULE16 - Bus dominant 100us gives remote wake
// RULE17 - Mode-enable high selects normal mode
// RULE18 - Watchdog control low enables watchdog
// RULE19 - Enable fall: silent if transmit high, else sleep
// RULE20 - Reset assertion in normal gives fail-safe
// RULE21 - Timers are restarting counters on clock
module ltc_transceiver_ctrl #(
   parameter int DOM_TIMEOUT = ltc_pkg::DOM_TIMEOUT_CYC,
   parameter int RESET_HOLD = ltc_pkg::RESET_HOLD_CYC
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // Host pins
   input wire logic txdIn,
   output logic txdOut,
   output logic txdOe,
   output logic rxd,
   input wire logic modeEnable,
   input wire logic wdogCtrl,
   // Bus
   input wire logic busIn,
   output logic busDriveDominant,
   // Analog monitors
   input wire logic supplyUnderVolt,
   input wire logic regUnderVolt,
   input wire logic busOverTemp,
   // Status outputs
   output logic undervoltage_reset_n,
   output logic regulatorOn,
   output logic watchdogEnable,
   output logic [1:0] opMode
);
   ////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [1:0] txdS, enS, busS, wdS, svS, rvS, otS;
   logic txd, en, bus, wdc, sv, rv, ot;

   // Two flops per asynchronous input
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txdS <= 2'h3;
         enS <= 2'h0;
         busS <= 2'h3;
         wdS <= 2'h0;
         svS <= 2'h0;
         rvS <= 2'h3;
         otS <= 2'h0;
      end
      else if (clkEn)
      begin
         txdS <= {txdS[0], txdIn};
         enS <= {enS[0], modeEnable};
         busS <= {busS[0], busIn};
         wdS <= {wdS[0], wdogCtrl};
         svS <= {svS[0], supplyUnderVolt};
         rvS <= {rvS[0], regUnderVolt};
         otS <= {otS[0], busOverTemp};
      end
   end
   assign txd = txdS[1];
   assign en = enS[1];
   assign bus = busS[1];
   assign wdc = wdS[1];
   assign sv = svS[1];
   assign rv = rvS[1];
   assign ot = otS[1];

   ////////////////////////////////////////////////////////////////////
   // Timers
   logic rearmDone, domDone, wakeDone, resFallDone, resHoldDone;

   // High transmit long enough to arm driver [RULE2] [RULE4] [RULE21]
   ltc_timer #(.LIMIT(ltc_pkg::REARM_CYC)) uRearm (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
      .cond(txd), .done(rearmDone));
   // Dominant time-out on the transmit input [RULE3] [RULE21]
   ltc_timer #(.LIMIT(DOM_TIMEOUT)) uDom (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
      .cond(!txd), .done(domDone));
   // Bus dominant filter for remote wake [RULE16] [RULE21]
   ltc_timer #(.LIMIT(ltc_pkg::WAKE_DOM_CYC)) uWake (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
      .cond(!bus), .done(wakeDone));
   // Reset fall delay [RULE10] [RULE21]
   ltc_timer #(.LIMIT(ltc_pkg::RESET_FALL_CYC)) uResFall (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
      .cond(rv), .done(resFallDone));
   // Reset release hold [RULE11] [RULE21]
   ltc_timer #(.LIMIT(RESET_HOLD)) uResHold (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
      .cond(!rv), .done(resHoldDone));

   ////////////////////////////////////////////////////////////////////
   // Mode and driver state
   ltc_pkg::ltc_mode_t mode, next_mode;
   logic armed, next_armed;
   logic wakePend, next_wakePend;
   logic enPrev;
   logic [1:0] fsSrc, next_fsSrc;
   logic resetN, next_resetN;

   // Next mode, driver arming and reset output
   always_comb
   begin
      next_mode = mode;
      next_armed = armed;
      next_wakePend = wakePend;
      next_fsSrc = fsSrc;
      next_resetN = resetN;
      // Reset output: assert after fall delay, release after hold
      if (resFallDone)
      begin
         next_resetN = 1'b0; // [RULE10]
      end
      else if (resHoldDone)
      begin
         next_resetN = 1'b1; // [RULE11]
      end
      // Driver arming: cleared on time-out, set after high interval
      if (domDone)
      begin
         next_armed = 1'b0; // [RULE3]
      end
      else if (rearmDone)
      begin
         next_armed = 1'b1; // [RULE4]
      end
      // Remote wake: filtered dominant, then released bus
      if ((mode == ltc_pkg::MODE_SLEEP) || (mode == ltc_pkg::MODE_SILENT))
      begin
         if (wakeDone)
         begin
            next_wakePend = 1'b1; // [RULE16]
         end
         if (wakePend && bus)
         begin
            next_wakePend = 1'b0;
            next_mode = ltc_pkg::MODE_FAILSAFE; // [RULE15]
            next_fsSrc = ltc_pkg::SRC_WAKE;
         end
      end
      else
      begin
         next_wakePend = 1'b0;
      end
      case (mode)
         ltc_pkg::MODE_NORMAL:
         begin
            if (!resetN)
            begin
               next_mode = ltc_pkg::MODE_FAILSAFE; // [RULE20]
               next_fsSrc = ltc_pkg::SRC_UNDERVOLT;
            end
            else if (enPrev && !en)
            begin
               // Raw level decides, time-out does not [RULE13] [RULE14] [RULE19]
               next_mode = txd ? ltc_pkg::MODE_SILENT : ltc_pkg::MODE_SLEEP;
            end
         end
         ltc_pkg::MODE_FAILSAFE, ltc_pkg::MODE_SILENT, ltc_pkg::MODE_SLEEP:
         begin
            if (en && resetN && (next_mode == mode))
            begin
               next_mode = ltc_pkg::MODE_NORMAL; // [RULE17]
               next_armed = 1'b0; // [RULE2]
            end
         end
         default:
         begin
            next_mode = ltc_pkg::MODE_FAILSAFE;
         end
      endcase
   end

   // State registers; power-up enters fail-safe [RULE8]
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode <= ltc_pkg::MODE_FAILSAFE;
         armed <= 1'b0;
         wakePend <= 1'b0;
         enPrev <= 1'b0;
         fsSrc <= ltc_pkg::SRC_POWERUP;
         resetN <= 1'b0;
      end
      else if (clkEn)
      begin
         mode <= next_mode;
         armed <= next_armed;
         wakePend <= next_wakePend;
         enPrev <= en;
         fsSrc <= next_fsSrc;
         resetN <= next_resetN;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output stage
   logic next_drive, next_rxd, next_txdOut, next_txdOe;

   // Pin values from mode and gating
   always_comb
   begin
      // Dominant only when armed, in normal, supply and temperature good
      next_drive = (mode == ltc_pkg::MODE_NORMAL) && armed && !txd && !domDone
                   && !sv && !ot; // [RULE1] [RULE9] [RULE12]
      case (mode)
         ltc_pkg::MODE_NORMAL: next_rxd = bus; // [RULE5]
         ltc_pkg::MODE_SILENT: next_rxd = 1'b1; // [RULE6]
         ltc_pkg::MODE_FAILSAFE: next_rxd = 1'b1;
         default: next_rxd = 1'b0;
      endcase
      // Transmit pin becomes an output in fail-safe [RULE7]
      next_txdOe = (mode == ltc_pkg::MODE_FAILSAFE);
      next_txdOut = (fsSrc == ltc_pkg::SRC_WAKE);
   end

   // Output registers
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busDriveDominant <= 1'b0;
         rxd <= 1'b1;
         txdOut <= 1'b0;
         txdOe <= 1'b0;
         undervoltage_reset_n <= 1'b0;
         regulatorOn <= 1'b1;
         watchdogEnable <= 1'b0;
         opMode <= 2'h0;
      end
      else if (clkEn)
      begin
         busDriveDominant <= next_drive;
         rxd <= next_rxd;
         txdOut <= next_txdOut;
         txdOe <= next_txdOe;
         undervoltage_reset_n <= resetN;
         regulatorOn <= (mode != ltc_pkg::MODE_SLEEP); // [RULE8] [RULE12]
         watchdogEnable <= !wdc; // [RULE18]
         opMode <= mode;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   chk_drive_timeout: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
      (clkEn && domDone) |=> !busDriveDominant)
      else $error("Driver active after dominant time-out");
   chk_silent_rxd: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
      (clkEn && mode == ltc_pkg::MODE_SILENT) |=> rxd)
      else $error("Receive output low in silent mode");
   chk_supply_gate: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE9]
      (clkEn && sv) |=> !busDriveDominant)
      else $error("Driving during supply undervoltage");
   chk_temp_gate: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE12]
      (clkEn && ot) |=> (!busDriveDominant && regulatorOn == ($past(mode) != ltc_pkg::MODE_SLEEP)))
      else $error("Driving during overtemperature");
   chk_failsafe_oe: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
      (clkEn && mode == ltc_pkg::MODE_FAILSAFE) |=> txdOe)
      else $error("Transmit pin not output in fail-safe");
   chk_sleep_raw: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE14]
      (clkEn && mode == ltc_pkg::MODE_NORMAL && resetN && enPrev && !en && !txd)
      |=> mode == ltc_pkg::MODE_SLEEP)
      else $error("Sleep not taken on raw low transmit");
   chk_reset_fail: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE20]
      (clkEn && mode == ltc_pkg::MODE_NORMAL && !resetN) |=> mode == ltc_pkg::MODE_FAILSAFE)
      else $error("No fail-safe after reset assertion");
   chk_wdog_pin: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE18]
      clkEn |=> watchdogEnable == !$past(wdc))
      else $error("Watchdog enable mismatch");
   chk_normal_arm: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE2]
      (clkEn && mode != ltc_pkg::MODE_NORMAL && next_mode == ltc_pkg::MODE_NORMAL)
      |=> !armed ##1 !busDriveDominant)
      else $error("Driver armed on normal entry");
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the transceiver control
module tb_top;
   // Clock, reset and stimulus
   logic sys_clk, nrst, clkEn, txReq, enReq, wdogCtrl, busIn;
   logic supplyUnderVolt, regUnderVolt, busOverTemp;
   // Device outputs and pins
   logic txdIn, txdOut, txdOe, rxd, modeEnable, busDriveDominant;
   logic undervoltage_reset_n, regulatorOn, watchdogEnable;
   logic [1:0] opMode;
   // Counters and seed
   int fail_count, checked, seed, i;
   ////////////////////////////////////////////////////////////////////////////////
   // Short timers so the run stays small
   ltc_transceiver_ctrl #(.DOM_TIMEOUT(50), .RESET_HOLD(20)) dut (.sys_clk(sys_clk), .nrst(nrst),
      .clkEn(clkEn), .txdIn(txdIn), .txdOut(txdOut), .txdOe(txdOe), .rxd(rxd), .modeEnable(modeEnable),
      .wdogCtrl(wdogCtrl), .busIn(busIn), .busDriveDominant(busDriveDominant),
      .supplyUnderVolt(supplyUnderVolt), .regUnderVolt(regUnderVolt), .busOverTemp(busOverTemp),
      .undervoltage_reset_n(undervoltage_reset_n), .regulatorOn(regulatorOn),
      .watchdogEnable(watchdogEnable), .opMode(opMode));
   // Host partner
   ltc_host_model host (.txReq(txReq), .enReq(enReq), .txdOut(txdOut), .txdOe(txdOe),
      .txdIn(txdIn), .modeEnable(modeEnable));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock generator
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Verdict and end of run
   task summarize();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Compare seen against expected
   task chk(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Step falling edges
   task cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // Bounded wait: sel 1 watches the mode, sel 0 the reset output
   task waitFor(input int sel, input logic [1:0] v);
      int k;
      k = 0;
      while ((sel ? opMode : {1'b0, undervoltage_reset_n}) !== v && k < 3000)
      begin
         cyc(1);
         k++;
      end
      if (k == 3000)
      begin
         fail_count++;
         $display("[ERR] %0t wait expired", $time);
         summarize();
      end
   endtask
   // Expected driver state from pin and monitors
   function automatic logic expDrive(input logic tx, input logic uv, input logic ot);
      return !tx && !uv && !ot;
   endfunction
   // Enter normal mode and re-arm the driver
   task goNormal();
      txReq = 1'b1;
      enReq = 1'b1;
      waitFor(1, 2'h1);
      cyc(110);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard
   initial
   begin
      #5000000;
      fail_count++;
      $display("[ERR] %0t run limit", $time);
      summarize();
   end
   // Main sequence
   initial
   begin
      {nrst, txReq, enReq, wdogCtrl, busIn, supplyUnderVolt, regUnderVolt, busOverTemp} = 8'h18;
      clkEn = 1'b1;
      fail_count = 0;
      checked = 0;
      seed = 69;
      cyc(4);
      nrst = 1'b1;
      cyc(5);
      chk(opMode, 2'h0);
      chk(regulatorOn, 1'b1);
      chk({txdOe, txdOut}, 2'h2);
      chk(undervoltage_reset_n, 1'b0);
      waitFor(0, 2'h1);
      for (i = 0; i < 2; i++)
      begin
         wdogCtrl = i[0];
         cyc(5);
         chk(watchdogEnable, !i[0]);
      end
      // Normal entry with transmit held low
      txReq = 1'b0;
      enReq = 1'b1;
      waitFor(1, 2'h1);
      cyc(30);
      chk(busDriveDominant, 1'b0);
      txReq = 1'b1;
      cyc(110);
      // Random traffic, never low long enough to time out
      for (i = 0; i < 150; i++)
      begin
         txReq = 1'($random(seed)) | (i % 8 == 7);
         busIn = 1'($random(seed));
         cyc(6);
         chk(busDriveDominant, expDrive(txReq, 1'b0, 1'b0));
         chk(rxd, busIn);
      end
      // Clock enable low freezes the receive path
      clkEn = 1'b0;
      busIn = !rxd;
      cyc(6);
      chk(rxd, !busIn);
      clkEn = 1'b1;
      // Stuck low, then short and full re-arm
      busIn = 1'b1;
      txReq = 1'b0;
      cyc(6);
      chk(busDriveDominant, 1'b1);
      cyc(60);
      chk(busDriveDominant, 1'b0);
      txReq = 1'b1;
      cyc(50);
      txReq = 1'b0;
      cyc(6);
      chk(busDriveDominant, 1'b0);
      txReq = 1'b1;
      cyc(110);
      txReq = 1'b0;
      cyc(6);
      chk(busDriveDominant, 1'b1);
      txReq = 1'b1;
      cyc(110);
      // Supply undervoltage, then overtemperature
      for (i = 0; i < 2; i++)
      begin
         supplyUnderVolt = (i == 0);
         busOverTemp = (i == 1);
         txReq = 1'b0;
         cyc(6);
         chk(busDriveDominant, expDrive(1'b0, supplyUnderVolt, busOverTemp));
         chk(regulatorOn, 1'b1);
         {supplyUnderVolt, busOverTemp, txReq} = 3'h1;
         cyc(110);
      end
      // Sleep with transmit stuck low past the time-out
      txReq = 1'b0;
      cyc(60);
      enReq = 1'b0;
      waitFor(1, 2'h3);
      chk(regulatorOn, 1'b0);
      // Bus wake: long dominant that then ends
      busIn = 1'b0;
      cyc(1100);
      busIn = 1'b1;
      waitFor(1, 2'h0);
      cyc(4);
      chk({txdOe, txdOut}, 2'h3);
      // Silent mode ignores the bus
      goNormal();
      enReq = 1'b0;
      waitFor(1, 2'h2);
      busIn = 1'b0;
      cyc(6);
      chk(rxd, 1'b1);
      busIn = 1'b1;
      // Regulator undervoltage from normal mode
      goNormal();
      regUnderVolt = 1'b1;
      cyc(50);
      chk(undervoltage_reset_n, 1'b1);
      waitFor(0, 2'h0);
      waitFor(1, 2'h0);
      regUnderVolt = 1'b0;
      cyc(10);
      chk(undervoltage_reset_n, 1'b0);
      waitFor(0, 2'h1);
      summarize();
   end
endmodule
